// ===== rtl/mrc_pkg.sv
package mrc_pkg;

	// register indices on the serial link (5-bit register field)
	localparam logic [4:0] ADDR_I_WAVE = 5'h01;
	localparam logic [4:0] ADDR_V_WAVE = 5'h02;
	localparam logic [4:0] ADDR_I_RMS = 5'h03;
	localparam logic [4:0] ADDR_V_RMS = 5'h04;
	localparam logic [4:0] ADDR_I_QUICK = 5'h05;
	localparam logic [4:0] ADDR_POWER = 5'h06;
	localparam logic [4:0] ADDR_PULSE_CNT = 5'h07;
	localparam logic [4:0] ADDR_LINE_RATE = 5'h08;
	localparam logic [4:0] ADDR_FLAGS = 5'h09;
	localparam logic [4:0] ADDR_RMS_OFS = 5'h12;
	localparam logic [4:0] ADDR_NOLOAD_TH = 5'h14;
	localparam logic [4:0] ADDR_OC_TH = 5'h15;
	localparam logic [4:0] ADDR_QUICK_CYC = 5'h16;
	localparam logic [4:0] ADDR_RATE_CYC = 5'h17;
	localparam logic [4:0] ADDR_ROUTING = 5'h18;
	localparam logic [4:0] ADDR_OPCFG = 5'h19;
	localparam logic [4:0] ADDR_GAIN = 5'h1a;
	localparam logic [4:0] ADDR_SRST_KEY = 5'h1c;
	localparam logic [4:0] ADDR_UNLOCK = 5'h1d;

	// values after reset
	localparam logic [15:0] RST_LINE_RATE = 16'h4e20;
	localparam logic [7:0] RST_NOLOAD_TH = 8'h0b;
	localparam logic [15:0] RST_OC_TH = 16'hffff;
	localparam logic [2:0] RST_QUICK_CYC = 3'h1;
	localparam logic [1:0] RST_RATE_CYC = 2'h3;
	localparam logic [5:0] RST_ROUTING = 6'h24;
	localparam logic [9:0] RST_OPCFG = 10'h087;
	localparam logic [1:0] RST_GAIN = 2'h2;
	localparam logic [1:0] OPCFG_RSVD = 2'h3;

	// keys
	localparam logic [23:0] SRST_KEY = 24'h5a_5a5a;
	localparam logic [7:0] UNLOCK_KEY = 8'h55;

	// operating config bit positions
	localparam int OPCFG_PULSE_EN = 2;
	localparam int OPCFG_RMS_SLOW = 3;
	localparam int OPCFG_QUICK_AC = 4;
	localparam int OPCFG_LINE_60 = 5;
	localparam int OPCFG_CLR_READ = 6;
	localparam int OPCFG_ABS_ACC = 7;
	localparam int OPCFG_BAUD_LO = 8;

	// frame header layout: {read, unit[1:0], register[4:0]}
	localparam int HDR_READ = 7;
	localparam int HDR_UNIT_LO = 5;

	// output source codes
	localparam logic [1:0] SRC_PULSE = 2'h0;
	localparam logic [1:0] SRC_OVERCUR = 2'h1;
	localparam logic [1:0] SRC_VCROSS = 2'h2;
	localparam logic [1:0] SRC_ICROSS = 2'h3;

	// timing
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned RMS_FAST_MS = 400;
	localparam int unsigned RMS_SLOW_MS = 800;
	localparam int unsigned RMS_FAST_CYC = RMS_FAST_MS * (CLK_HZ / 1000);
	localparam int unsigned RMS_SLOW_CYC = RMS_SLOW_MS * (CLK_HZ / 1000);
	localparam int unsigned BAUD_4800 = 4800;
	localparam int unsigned BAUD_9600 = 9600;
	localparam int unsigned BAUD_19200 = 19200;
	localparam int unsigned BAUD_38400 = 38400;
	localparam int unsigned BIT_4800_CYC = CLK_HZ / BAUD_4800;
	localparam int unsigned BIT_9600_CYC = CLK_HZ / BAUD_9600;
	localparam int unsigned BIT_19200_CYC = CLK_HZ / BAUD_19200;
	localparam int unsigned BIT_38400_CYC = CLK_HZ / BAUD_38400;

	// frame states
	typedef enum logic [1:0] {
		FR_HEAD = 2'b00,
		FR_DATA = 2'b01,
		FR_SKIP = 2'b10
	} mrc_frame_t;

	// measurement results and events from the metering core
	typedef struct packed {
		logic [19:0] i_wave;
		logic [19:0] v_wave;
		logic [23:0] i_rms;
		logic [23:0] v_rms;
		logic [23:0] i_quick;
		logic [23:0] power;
		logic [15:0] line_rate;
		logic line_rate_valid;
		logic pulse_level;
		logic pulse_evt;
		logic pulse_reverse;
		logic noload;
		logic i_cross_low;
		logic v_cross_low;
		logic overcurrent;
		logic v_cross;
		logic i_cross;
	} mrc_meas_t;

	// settings handed to the metering core
	typedef struct packed {
		logic [7:0] rms_offset;
		logic [7:0] noload_th;
		logic [15:0] oc_th;
		logic [2:0] quick_cycles;
		logic [1:0] rate_cycles;
		logic pulse_enable;
		logic rms_slow;
		logic quick_ac;
		logic line_60hz;
		logic [1:0] gain_code;
	} mrc_cfg_t;

endpackage

// ===== rtl/mrc_regs.sv
`timescale 1ns/1ps
`default_nettype none

module mrc_regs
	import mrc_pkg::*;
#(
	parameter int unsigned RMS_FAST_CYC_P = RMS_FAST_CYC,
	parameter int unsigned RMS_SLOW_CYC_P = RMS_SLOW_CYC,
	parameter int unsigned BIT_4800_CYC_P = BIT_4800_CYC,
	parameter int unsigned BIT_9600_CYC_P = BIT_9600_CYC,
	parameter int unsigned BIT_19200_CYC_P = BIT_19200_CYC,
	parameter int unsigned BIT_38400_CYC_P = BIT_38400_CYC
) (
	// clock, reset, enable
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	// serial pins and straps
	input wire logic iface_select_pin,
	input wire logic rate_or_clock_pin,
	input wire logic receive_data_in_pin,
	input wire logic unit_address_strap_low,
	input wire logic unit_address_or_chip_select,
	output logic transmit_data_out_pin,
	output logic transmit_data_out_oe,
	// logic output pins
	output logic logic_output_one,
	output logic logic_output_two,
	output logic crossing_output_pin,
	// metering core side
	input wire mrc_meas_t meas,
	output mrc_cfg_t cfg,
	output logic rms_refresh_tick,
	output logic soft_reset_pulse
);

	// synchroniser indices
	localparam int P_SEL = 0;
	localparam int P_RATE = 1;
	localparam int P_RX = 2;
	localparam int P_A1 = 3;
	localparam int P_A2 = 4;

	logic [4:0] pin_s1_r; // first stage, read only by second
	logic [4:0] pin_s2_r; // safe pin levels
	logic sclk_d_r; // previous safe clock level for edges
	logic rst_all; // external or key reset
	logic spi_mode;
	logic cs_act;
	logic sclk_rise;
	logic sclk_fall;

	// register file
	logic [7:0] rms_ofs_r;
	logic [7:0] noload_th_r;
	logic [15:0] oc_th_r;
	logic [2:0] quick_cyc_r;
	logic [1:0] rate_cyc_r;
	logic [5:0] routing_r;
	logic [9:2] opcfg_r; // bits 1:0 are fixed reserved
	logic [1:0] gain_r;
	logic [23:0] srst_key_r;
	logic [7:0] unlock_r;
	logic [23:0] pulse_cnt_r;
	logic [15:0] line_rate_r;
	logic rev_flag_r;

	// frame engine
	mrc_frame_t fr_state_r;
	logic [1:0] fr_cnt_r;
	logic [7:0] hdr_r;
	logic [23:0] wdata_r;
	logic byte_v;
	logic [7:0] byte_d;
	logic hit;
	logic read_go;
	logic write_go;
	logic [23:0] rdat;

	// serial engines
	logic [7:0] spi_sh_r;
	logic [2:0] spi_bits_r;
	logic spi_v_r;
	logic urx_busy_r;
	logic [15:0] urx_div_r;
	logic [3:0] urx_bits_r;
	logic [7:0] urx_sh_r;
	logic urx_v_r;
	logic [23:0] tx_dat_r;
	logic [1:0] utx_left_r;
	logic utx_busy_r;
	logic [8:0] utx_sh_r;
	logic [3:0] utx_bits_r;
	logic [15:0] utx_div_r;
	logic [15:0] baud_cyc;
	logic [26:0] rms_cnt_r;

	// pin synchroniser and clock edge history
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pin_s1_r <= 5'h00;
			pin_s2_r <= 5'h00;
			sclk_d_r <= 1'b0;
		end else if (ce) begin
			pin_s1_r <= {unit_address_or_chip_select, unit_address_strap_low,
				receive_data_in_pin, rate_or_clock_pin, iface_select_pin};
			pin_s2_r <= pin_s1_r;
			sclk_d_r <= pin_s2_r[P_RATE];
		end
	end

	assign spi_mode = pin_s2_r[P_SEL];
	// chip select active low in SPI
	assign cs_act = spi_mode & ~pin_s2_r[P_A2];
	// rate pin is the SPI clock here
	assign sclk_rise = cs_act & pin_s2_r[P_RATE] & ~sclk_d_r;
	assign sclk_fall = cs_act & ~pin_s2_r[P_RATE] & sclk_d_r;
	assign rst_all = sys_rst | soft_reset_pulse;

	// key reset held one cycle, cleared by itself
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			soft_reset_pulse <= 1'b0;
		end else if (ce) begin
			// an unaddressed unit on a shared uart ignores the key
			soft_reset_pulse <= write_go & hit & (hdr_r[4:0] == ADDR_SRST_KEY) & (wdata_r == SRST_KEY);
		end
	end

	// bit period from rate field and rate pin
	always_comb begin
		unique case (opcfg_r[OPCFG_BAUD_LO+1:OPCFG_BAUD_LO])
			2'b10: baud_cyc = 16'(BIT_19200_CYC_P);
			2'b11: baud_cyc = 16'(BIT_38400_CYC_P);
			default: baud_cyc = pin_s2_r[P_RATE] ? 16'(BIT_9600_CYC_P) : 16'(BIT_4800_CYC_P);
		endcase
	end

	// spi receive: one bit per rising clock edge
	always_ff @(posedge clk) begin
		if (rst_all) begin
			spi_sh_r <= 8'h00;
			spi_bits_r <= 3'h0;
			spi_v_r <= 1'b0;
		end else if (ce) begin
			spi_v_r <= 1'b0;
			if (!cs_act) begin
				// deselect drops any partial byte
				spi_bits_r <= 3'h0;
			end else if (sclk_rise) begin
				spi_sh_r <= {spi_sh_r[6:0], pin_s2_r[P_RX]};
				spi_bits_r <= spi_bits_r + 3'h1;
				spi_v_r <= (spi_bits_r == 3'h7);
			end
		end
	end

	// uart receive: 8N1, sampled mid-bit
	always_ff @(posedge clk) begin
		if (rst_all) begin
			urx_busy_r <= 1'b0;
			urx_div_r <= 16'h0000;
			urx_bits_r <= 4'h0;
			urx_sh_r <= 8'h00;
			urx_v_r <= 1'b0;
		end else if (ce) begin
			urx_v_r <= 1'b0;
			if (spi_mode) begin
				urx_busy_r <= 1'b0;
			end else if (!urx_busy_r) begin
				// falling start edge: wait half a bit
				if (!pin_s2_r[P_RX]) begin
					urx_busy_r <= 1'b1;
					urx_div_r <= baud_cyc >> 1;
					urx_bits_r <= 4'h0;
				end
			end else if (urx_div_r != 16'h0000) begin
				urx_div_r <= urx_div_r - 16'h0001;
			end else if (urx_bits_r == 4'h0) begin
				// glitch on start bit aborts
				urx_busy_r <= ~pin_s2_r[P_RX];
				urx_bits_r <= 4'h1;
				urx_div_r <= baud_cyc;
			end else if (urx_bits_r != 4'h9) begin
				urx_sh_r <= {pin_s2_r[P_RX], urx_sh_r[7:1]};
				urx_bits_r <= urx_bits_r + 4'h1;
				urx_div_r <= baud_cyc;
			end else begin
				// framing error drops the byte silently
				urx_busy_r <= 1'b0;
				urx_v_r <= pin_s2_r[P_RX];
			end
		end
	end

	assign byte_v = spi_mode ? spi_v_r : urx_v_r;
	assign byte_d = spi_mode ? spi_sh_r : urx_sh_r;
	// unit field must match straps in UART mode
	assign hit = spi_mode | (hdr_r[HDR_UNIT_LO+1:HDR_UNIT_LO] == {pin_s2_r[P_A2], pin_s2_r[P_A1]});

	// frame sequencer: header then three data bytes
	always_ff @(posedge clk) begin
		if (rst_all) begin
			fr_state_r <= FR_HEAD;
			fr_cnt_r <= 2'h0;
			hdr_r <= 8'h00;
			wdata_r <= 24'h00_0000;
			read_go <= 1'b0;
			write_go <= 1'b0;
		end else if (ce) begin
			read_go <= 1'b0;
			write_go <= 1'b0;
			if (spi_mode & !cs_act) begin
				fr_state_r <= FR_HEAD;
			end else if (byte_v) begin
				unique case (fr_state_r)
					FR_HEAD: begin
						hdr_r <= byte_d;
						fr_cnt_r <= 2'h0;
						read_go <= byte_d[HDR_READ];
						// spi read still clocks three dummy bytes
						if (!byte_d[HDR_READ]) fr_state_r <= FR_DATA;
						else if (spi_mode) fr_state_r <= FR_SKIP;
					end
					FR_DATA: begin
						// data field is 24 bits, msb first
						wdata_r <= {wdata_r[15:0], byte_d};
						fr_cnt_r <= fr_cnt_r + 2'h1;
						if (fr_cnt_r == 2'h2) begin
							write_go <= 1'b1;
							fr_state_r <= FR_HEAD;
						end
					end
					FR_SKIP: begin
						fr_cnt_r <= fr_cnt_r + 2'h1;
						if (fr_cnt_r == 2'h2) fr_state_r <= FR_HEAD;
					end
					default: fr_state_r <= FR_HEAD;
				endcase
			end
		end
	end

	// read mux, high bits zero-filled
	always_comb begin
		unique case (hdr_r[4:0])
			ADDR_I_WAVE: rdat = {4'h0, meas.i_wave};
			ADDR_V_WAVE: rdat = {4'h0, meas.v_wave};
			ADDR_I_RMS: rdat = meas.i_rms;
			ADDR_V_RMS: rdat = meas.v_rms;
			ADDR_I_QUICK: rdat = meas.i_quick;
			ADDR_POWER: rdat = meas.power;
			ADDR_PULSE_CNT: rdat = pulse_cnt_r;
			ADDR_LINE_RATE: rdat = {8'h00, line_rate_r};
			ADDR_FLAGS: rdat = {14'h0000, meas.v_cross_low, meas.i_cross_low, 6'h00, meas.noload, rev_flag_r};
			ADDR_RMS_OFS: rdat = {16'h0000, rms_ofs_r};
			ADDR_NOLOAD_TH: rdat = {16'h0000, noload_th_r};
			ADDR_OC_TH: rdat = {8'h00, oc_th_r};
			ADDR_QUICK_CYC: rdat = {21'h00_0000, quick_cyc_r};
			ADDR_RATE_CYC: rdat = {22'h00_0000, rate_cyc_r};
			ADDR_ROUTING: rdat = {18'h0_0000, routing_r};
			// reserved mode bits read their defaults
			ADDR_OPCFG: rdat = {14'h0000, opcfg_r, OPCFG_RSVD};
			ADDR_GAIN: rdat = {22'h00_0000, gain_r};
			ADDR_SRST_KEY: rdat = srst_key_r;
			ADDR_UNLOCK: rdat = {16'h0000, unlock_r};
			default: rdat = 24'h00_0000;
		endcase
	end

	// transmit: spi shifts on falling edges, uart sends three bytes
	always_ff @(posedge clk) begin
		if (rst_all) begin
			tx_dat_r <= 24'h00_0000;
			transmit_data_out_pin <= 1'b1;
			transmit_data_out_oe <= 1'b0;
			utx_left_r <= 2'h0;
			utx_busy_r <= 1'b0;
			utx_sh_r <= 9'h1ff;
			utx_bits_r <= 4'h0;
			utx_div_r <= 16'h0000;
		end else if (ce) begin
			transmit_data_out_oe <= spi_mode ? cs_act : 1'b1;
			if (spi_mode) begin
				utx_left_r <= 2'h0;
				utx_busy_r <= 1'b0;
				if (read_go) begin
					tx_dat_r <= rdat;
				end else if (sclk_fall) begin
					// host samples on the next rising edge
					transmit_data_out_pin <= tx_dat_r[23];
					tx_dat_r <= {tx_dat_r[22:0], 1'b0};
				end
			end else if (read_go & hit) begin
				// an unaddressed unit stays silent
				tx_dat_r <= rdat;
				utx_left_r <= 2'h3;
			end else if (!utx_busy_r) begin
				transmit_data_out_pin <= 1'b1;
				if (utx_left_r != 2'h0) begin
					transmit_data_out_pin <= 1'b0;
					utx_sh_r <= {1'b1, tx_dat_r[23:16]};
					tx_dat_r <= {tx_dat_r[15:0], 8'h00};
					utx_left_r <= utx_left_r - 2'h1;
					utx_busy_r <= 1'b1;
					utx_bits_r <= 4'h9;
					utx_div_r <= baud_cyc;
				end
			end else if (utx_div_r != 16'h0000) begin
				utx_div_r <= utx_div_r - 16'h0001;
			end else if (utx_bits_r == 4'h0) begin
				utx_busy_r <= 1'b0;
			end else begin
				transmit_data_out_pin <= utx_sh_r[0];
				utx_sh_r <= {1'b1, utx_sh_r[8:1]};
				utx_bits_r <= utx_bits_r - 4'h1;
				utx_div_r <= baud_cyc;
			end
		end
	end

	// user registers and keys
	always_ff @(posedge clk) begin
		if (rst_all) begin
			rms_ofs_r <= 8'h00;
			noload_th_r <= RST_NOLOAD_TH;
			oc_th_r <= RST_OC_TH;
			quick_cyc_r <= RST_QUICK_CYC;
			rate_cyc_r <= RST_RATE_CYC;
			// routing default pulse, overcurrent, voltage crossing
			routing_r <= RST_ROUTING;
			opcfg_r <= RST_OPCFG[9:2];
			gain_r <= RST_GAIN;
			srst_key_r <= 24'h00_0000;
			unlock_r <= 8'h00;
		end else if (ce & write_go & hit) begin
			// key registers are always writable
			if (hdr_r[4:0] == ADDR_SRST_KEY) srst_key_r <= wdata_r;
			if (hdr_r[4:0] == ADDR_UNLOCK) unlock_r <= wdata_r[7:0];
			if (unlock_r == UNLOCK_KEY) begin
				unique case (hdr_r[4:0])
					ADDR_RMS_OFS: rms_ofs_r <= wdata_r[7:0];
					ADDR_NOLOAD_TH: noload_th_r <= wdata_r[7:0];
					ADDR_OC_TH: oc_th_r <= wdata_r[15:0];
					ADDR_QUICK_CYC: quick_cyc_r <= wdata_r[2:0];
					ADDR_RATE_CYC: rate_cyc_r <= wdata_r[1:0];
					ADDR_ROUTING: routing_r <= wdata_r[5:0];
					ADDR_OPCFG: opcfg_r <= wdata_r[9:2];
					ADDR_GAIN: gain_r <= wdata_r[1:0];
					default: ;
				endcase
			end
		end
	end

	// pulse counter, direction flag, line rate capture
	always_ff @(posedge clk) begin
		if (rst_all) begin
			pulse_cnt_r <= 24'h00_0000;
			rev_flag_r <= 1'b0;
			line_rate_r <= RST_LINE_RATE;
		end else if (ce) begin
			logic [23:0] base;
			base = pulse_cnt_r;
			if (read_go & hit & (hdr_r[4:0] == ADDR_PULSE_CNT) & opcfg_r[OPCFG_CLR_READ]) base = 24'h00_0000;
			// counting only while enabled; a same-cycle pulse survives the clear
			if (meas.pulse_evt & opcfg_r[OPCFG_PULSE_EN]) begin
				if (meas.pulse_reverse & !opcfg_r[OPCFG_ABS_ACC]) base = base - 24'h00_0001;
				else base = base + 24'h00_0001;
				rev_flag_r <= meas.pulse_reverse;
			end
			pulse_cnt_r <= base;
			if (meas.line_rate_valid) line_rate_r <= meas.line_rate;
		end
	end

	// refresh tick every 400 or 800 ms
	always_ff @(posedge clk) begin
		if (rst_all) begin
			rms_cnt_r <= 27'h000_0000;
			rms_refresh_tick <= 1'b0;
		end else if (ce) begin
			rms_refresh_tick <= 1'b0;
			if (rms_cnt_r >= (opcfg_r[OPCFG_RMS_SLOW] ? 27'(RMS_SLOW_CYC_P - 1) : 27'(RMS_FAST_CYC_P - 1))) begin
				rms_cnt_r <= 27'h000_0000;
				rms_refresh_tick <= 1'b1;
			end else begin
				rms_cnt_r <= rms_cnt_r + 27'h000_0001;
			end
		end
	end

	// source selection for one output pin
	function automatic logic pick(input logic [1:0] sel, input logic pulse, input mrc_meas_t m);
		unique case (sel)
			SRC_PULSE: pick = pulse;
			SRC_OVERCUR: pick = m.overcurrent;
			SRC_VCROSS: pick = m.v_cross;
			SRC_ICROSS: pick = m.i_cross;
		endcase
	endfunction

	// routed output pins, pulse gated by enable
	always_ff @(posedge clk) begin
		if (rst_all) begin
			logic_output_one <= 1'b0;
			logic_output_two <= 1'b0;
			crossing_output_pin <= 1'b0;
		end else if (ce) begin
			logic_output_one <= pick(routing_r[1:0], meas.pulse_level & opcfg_r[OPCFG_PULSE_EN], meas);
			logic_output_two <= pick(routing_r[3:2], meas.pulse_level & opcfg_r[OPCFG_PULSE_EN], meas);
			crossing_output_pin <= pick(routing_r[5:4], meas.pulse_level & opcfg_r[OPCFG_PULSE_EN], meas);
		end
	end

	// settings to the core, registered
	always_ff @(posedge clk) begin
		if (rst_all) begin
			// reset values match the registers, so the core never sees all zeros
			cfg.rms_offset <= 8'h00;
			cfg.noload_th <= RST_NOLOAD_TH;
			cfg.oc_th <= RST_OC_TH;
			cfg.quick_cycles <= RST_QUICK_CYC;
			cfg.rate_cycles <= RST_RATE_CYC;
			cfg.pulse_enable <= RST_OPCFG[OPCFG_PULSE_EN];
			cfg.rms_slow <= RST_OPCFG[OPCFG_RMS_SLOW];
			cfg.quick_ac <= RST_OPCFG[OPCFG_QUICK_AC];
			cfg.line_60hz <= RST_OPCFG[OPCFG_LINE_60];
			cfg.gain_code <= RST_GAIN;
		end else if (ce) begin
			cfg.rms_offset <= rms_ofs_r;
			cfg.noload_th <= noload_th_r;
			cfg.oc_th <= oc_th_r;
			cfg.quick_cycles <= quick_cyc_r;
			cfg.rate_cycles <= rate_cyc_r;
			cfg.pulse_enable <= opcfg_r[OPCFG_PULSE_EN];
			cfg.rms_slow <= opcfg_r[OPCFG_RMS_SLOW];
			cfg.quick_ac <= opcfg_r[OPCFG_QUICK_AC];
			cfg.line_60hz <= opcfg_r[OPCFG_LINE_60];
			// gain code passed as is (1,4,16,24)
			cfg.gain_code <= gain_r;
		end
	end

endmodule

`default_nettype wire

// ===== sim/mrc_regs_checker.sv
`timescale 1ns/1ps
`default_nettype none
// watches the register block at its ports
module mrc_regs_checker
	import mrc_pkg::*;
#(
	parameter int unsigned RMS_FAST_CYC_P = RMS_FAST_CYC,
	parameter int unsigned RMS_SLOW_CYC_P = RMS_SLOW_CYC
) (
	// clock, reset, enable
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	// serial pins and straps
	input wire logic iface_select_pin,
	input wire logic rate_or_clock_pin,
	input wire logic receive_data_in_pin,
	input wire logic unit_address_strap_low,
	input wire logic unit_address_or_chip_select,
	input wire logic transmit_data_out_pin,
	input wire logic transmit_data_out_oe,
	// logic output pins
	input wire logic logic_output_one,
	input wire logic logic_output_two,
	input wire logic crossing_output_pin,
	// metering core side
	input wire mrc_meas_t meas,
	input wire mrc_cfg_t cfg,
	input wire logic rms_refresh_tick,
	input wire logic soft_reset_pulse
);
	// one clock domain, one reset
	default clocking dcb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	// the edge after release still shows what reset left behind
	reset_pins_a: assert property ($fell(sys_rst) |-> transmit_data_out_pin && !transmit_data_out_oe
		&& !logic_output_one && !logic_output_two && !crossing_output_pin) else $error("pins not idle after reset");
	reset_cfg_a: assert property ($fell(sys_rst) |-> cfg.pulse_enable && !cfg.rms_slow && !cfg.quick_ac
		&& !cfg.line_60hz && cfg.gain_code == RST_GAIN && cfg.oc_th == RST_OC_TH) else $error("cfg not reset");
	// uart keeps the transmit line driven; soft reset may blank it briefly
	uart_drive_a: assert property ((!iface_select_pin && !soft_reset_pulse) [*6] |-> transmit_data_out_oe)
		else $error("uart tx not driven");
	// spi drives the data line only while selected
	spi_idle_a: assert property ((iface_select_pin && unit_address_or_chip_select) [*5]
		|-> !transmit_data_out_oe) else $error("spi tx driven while deselected");
	spi_drive_a: assert property ((iface_select_pin && !unit_address_or_chip_select && !soft_reset_pulse) [*6]
		|-> transmit_data_out_oe) else $error("spi tx not driven while selected");
	// no frame on the link, no change of settings
	cfg_quiet_a: assert property ((iface_select_pin && unit_address_or_chip_select) [*8] |-> $stable(cfg))
		else $error("cfg changed without a frame");
	srst_once_a: assert property (soft_reset_pulse |=> !soft_reset_pulse)
		else $error("soft reset longer than one cycle");
	srst_cfg_a: assert property (soft_reset_pulse |-> ##[1:3] (cfg.gain_code == RST_GAIN && cfg.pulse_enable))
		else $error("soft reset left cfg");
	// main scenarios reached
	srst_c: cover property (soft_reset_pulse);
	slow_tick_c: cover property (rms_refresh_tick && cfg.rms_slow);
	uart_c: cover property (!iface_select_pin && transmit_data_out_oe);
endmodule
bind mrc_regs mrc_regs_checker #(.RMS_FAST_CYC_P(RMS_FAST_CYC_P), .RMS_SLOW_CYC_P(RMS_SLOW_CYC_P)) i_chk (
	.clk(clk), .sys_rst(sys_rst), .ce(ce), .iface_select_pin(iface_select_pin),
	.rate_or_clock_pin(rate_or_clock_pin), .receive_data_in_pin(receive_data_in_pin),
	.unit_address_strap_low(unit_address_strap_low), .unit_address_or_chip_select(unit_address_or_chip_select),
	.transmit_data_out_pin(transmit_data_out_pin), .transmit_data_out_oe(transmit_data_out_oe),
	.logic_output_one(logic_output_one), .logic_output_two(logic_output_two),
	.crossing_output_pin(crossing_output_pin), .meas(meas), .cfg(cfg),
	.rms_refresh_tick(rms_refresh_tick), .soft_reset_pulse(soft_reset_pulse));
`default_nettype wire

// ===== sim/mrc_host.sv
`timescale 1ns/1ps
`default_nettype none
// spi host; link clock stands low between frames
module mrc_host (
	// link pins
	output logic sclk,
	output logic cs_n,
	output logic sdi,
	input wire logic sdo
);
	// idle link
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		sdi = 1'b0;
	end
	// one frame: header then data, msb first, 125 ns link clock
	// value in a 24-bit field
	task automatic xfer(input logic [7:0] hdr, input logic [23:0] wd, output logic [23:0] rd);
		logic [31:0] sh;
		sh = {hdr, wd};
		rd = 24'h00_0000;
		cs_n = 1'b0;
		for (int i = 31; i >= 0; i--) begin
			sdi = sh[i];
			#62.5 sclk = 1'b1;
			if (i < 24) rd[i] = sdo;
			#62.5 sclk = 1'b0;
		end
		#62.5 cs_n = 1'b1;
		// released line flips so a stale level is never trusted
		sdi = ~sdi;
		#200;
	endtask
	// uart bit time: the bench shortens the 4800 setting to 16 clocks
	localparam real UBIT = 160.0;
	// uart read: header lsb first, then three reply bytes, high byte first
	// host bit time is fixed at UBIT, so it matches only the bench's shortened 4800 setting
	task automatic uread(input logic [7:0] hdr, output logic [23:0] rd);
		logic [8:0] f;
		f = {hdr, 1'b0};
		rd = 24'h00_0000;
		for (int i = 0; i < 9; i++) begin
			sdi = f[i];
			#UBIT;
		end
		// stop bit stands while the reply comes back
		sdi = 1'b1;
		for (int b = 2; b >= 0; b--) begin
			@(negedge sdo);
			#(UBIT * 1.5);
			for (int i = 0; i < 8; i++) begin
				rd[8 * b + i] = sdo;
				#UBIT;
			end
		end
	endtask
endmodule
`default_nettype wire

// ===== sim/metering_register_config_test.sv
`timescale 1ns/1ps
`default_nettype none
// spi host traffic against the register block
module metering_register_config_test
	import mrc_pkg::*;
;
	// clock, reset, core stimulus
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic sel = 1'b1;
	mrc_meas_t meas = '0;
	// device outputs and link wires
	mrc_cfg_t cfg;
	logic sclk, cs_n, sdi, sdo, txp, oe, out1, out2, outx, tick, srst;
	logic a1 = 1'b1; // with chip select idle high the uart unit is 11
	logic [23:0] ugot;
	// pull-up holds the line whenever the device lets go of it
	assign sdo = oe ? txp : 1'b1;
	// verdict counters
	int num_errors = 0;
	int num_checks = 0;
	int cyc = 0;
	// registers and their values after reset
	localparam logic [4:0] RA[11] = '{ADDR_LINE_RATE, ADDR_FLAGS, ADDR_RMS_OFS, ADDR_NOLOAD_TH, ADDR_OC_TH,
		ADDR_QUICK_CYC, ADDR_RATE_CYC, ADDR_ROUTING, ADDR_OPCFG, ADDR_GAIN, ADDR_UNLOCK};
	localparam logic [23:0] RV[11] = '{24'h00_4e20, 24'h00_0000, 24'h00_0000, 24'h00_000b, 24'h00_ffff,
		24'h00_0001, 24'h00_0003, 24'h00_0024, 24'h00_0087, 24'h00_0002, 24'h00_0000};
	always #5 clk = ~clk;
	// short refresh periods and a 16-clock uart bit keep the run brief
	mrc_regs #(.RMS_FAST_CYC_P(200), .RMS_SLOW_CYC_P(400), .BIT_4800_CYC_P(15)) i_dut (
		.clk(clk), .sys_rst(sys_rst), .ce(1'b1), .iface_select_pin(sel), .rate_or_clock_pin(sclk),
		.receive_data_in_pin(sdi), .unit_address_strap_low(a1), .unit_address_or_chip_select(cs_n),
		.transmit_data_out_pin(txp), .transmit_data_out_oe(oe), .logic_output_one(out1),
		.logic_output_two(out2), .crossing_output_pin(outx), .meas(meas), .cfg(cfg),
		.rms_refresh_tick(tick), .soft_reset_pulse(srst));
	mrc_host i_host (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));
	// end of run with counts
	task automatic print_verdict();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// compare a register value
	task automatic chk_reg(input string what, input logic [23:0] exp, input logic [23:0] got);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	// compare one bit
	task automatic chk_bit(input string what, input logic exp, input logic got);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %b seen %b", what, exp, got);
		end
	endtask
	// register write and checked read
	task automatic wr(input logic [4:0] a, input logic [23:0] d);
		logic [23:0] unused;
		i_host.xfer({3'b000, a}, d, unused);
	endtask
	task automatic rd(input logic [4:0] a, input logic [23:0] exp);
		logic [23:0] got;
		i_host.xfer({3'b100, a}, 24'h00_0000, got);
		chk_reg($sformatf("reg %h", a), exp, got);
	endtask
	// drive the four pin sources and let the routed outputs settle
	task automatic src(input logic [3:0] s);
		@(posedge clk) #1;
		{meas.i_cross, meas.v_cross, meas.overcurrent, meas.pulse_level} = s;
		repeat (3) @(posedge clk);
		#1;
	endtask
	// one energy pulse with its direction
	task automatic pulse(input logic rev);
		@(posedge clk) #1;
		meas.pulse_evt = 1'b1;
		meas.pulse_reverse = rev;
		@(posedge clk) #1;
		meas.pulse_evt = 1'b0;
	endtask
	// cycles between two refresh ticks
	task automatic gap(input logic [23:0] exp);
		logic [23:0] n;
		do @(posedge clk) #1; while (tick !== 1'b1);
		n = 24'h00_0000;
		do begin
			@(posedge clk) #1;
			n++;
		end while (tick !== 1'b1);
		chk_reg("refresh gap", exp, n);
	endtask
	// hang guard; a long stall counts as a mismatch
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			num_errors++;
			print_verdict();
		end
	end
	// main sequence
	initial begin
		repeat (3) @(posedge clk);
		#1 sys_rst = 1'b0;
		repeat (5) @(posedge clk);
		for (int i = 0; i < 11; i++) rd(RA[i], RV[i]);
		src(4'b1010);
		chk_bit("out1", 1'b0, out1);
		chk_bit("out2", 1'b1, out2);
		chk_bit("outx", 1'b0, outx);
		// locked, then unlocked
		wr(ADDR_GAIN, 24'h00_0000);
		rd(ADDR_GAIN, 24'h00_0002);
		wr(ADDR_UNLOCK, 24'h00_0055);
		wr(ADDR_GAIN, 24'h00_0003);
		rd(ADDR_GAIN, 24'h00_0003);
		chk_reg("gain", 24'h00_0003, {22'h00_0000, cfg.gain_code});
		wr(ADDR_LINE_RATE, 24'h12_3456);
		rd(ADDR_LINE_RATE, 24'h00_4e20);
		// every writable mode bit set; reserved ones stay put
		wr(ADDR_OPCFG, 24'hff_ffff);
		rd(ADDR_OPCFG, 24'h00_03ff);
		chk_bit("slow", 1'b1, cfg.rms_slow);
		chk_bit("ac", 1'b1, cfg.quick_ac);
		chk_bit("60hz", 1'b1, cfg.line_60hz);
		gap(24'd400);
		@(posedge clk) #1;
		meas.i_wave = 20'h8_1234;
		meas.v_wave = 20'hf_fffe;
		rd(ADDR_I_WAVE, 24'h08_1234);
		rd(ADDR_V_WAVE, 24'h0f_fffe);
		// absolute counting, clear on read
		pulse(1'b1);
		pulse(1'b0);
		pulse(1'b1);
		meas.noload = 1'b1;
		meas.i_cross_low = 1'b1;
		meas.v_cross_low = 1'b1;
		rd(ADDR_FLAGS, 24'h00_0303);
		rd(ADDR_PULSE_CNT, 24'h00_0003);
		rd(ADDR_PULSE_CNT, 24'h00_0000);
		// signed counting, fast refresh
		wr(ADDR_OPCFG, 24'h00_0047);
		pulse(1'b1);
		rd(ADDR_PULSE_CNT, 24'hff_ffff);
		gap(24'd200);
		for (int c = 0; c < 4; c++) begin
			wr(ADDR_ROUTING, {18'h0_0000, c[1:0], c[1:0], c[1:0]});
			src(4'h1 << c);
			chk_bit("out1 on", 1'b1, out1);
			chk_bit("out2 on", 1'b1, out2);
			chk_bit("outx on", 1'b1, outx);
			src(~(4'h1 << c));
			chk_bit("outx off", 1'b0, outx);
		end
		// accumulation off: pulses not counted
		wr(ADDR_OPCFG, 24'h00_0043);
		pulse(1'b0);
		rd(ADDR_PULSE_CNT, 24'h00_0000);
		chk_bit("pulse enable", 1'b0, cfg.pulse_enable);
		// wrong key, then the real one
		wr(ADDR_SRST_KEY, 24'h5a_5a5b);
		rd(ADDR_OPCFG, 24'h00_0043);
		wr(ADDR_SRST_KEY, 24'h5a_5a5a);
		rd(ADDR_OPCFG, 24'h00_0087);
		rd(ADDR_UNLOCK, 24'h00_0000);
		@(posedge clk) #1;
		sel = 1'b0;
		repeat (10) @(posedge clk);
		#1 chk_bit("uart oe", 1'b1, oe);
		// uart read of unit 11, rate pin low and rate field 00 give 4800
		i_host.uread({1'b1, 2'b11, ADDR_LINE_RATE}, ugot);
		chk_reg("uart line rate", 24'h00_4e20, ugot);
		print_verdict();
	end
endmodule
`default_nettype wire
